// ==== hdl/spe_cfg.svh ====
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH
// Short arbitrated reset length in ns and its cycle count at 20 MHz (rounded down, longest time)
`define SPE_CLK_NS 50
`define SPE_SHORT_RST_NS 1300
`define SPE_SHORT_RST_CYC ((`SPE_SHORT_RST_NS) / (`SPE_CLK_NS))
// Number of implemented ports
`define SPE_NUM_PORTS 1
// Reset values
`define SPE_PAGE_RST 3'h0
`define SPE_PORT_RST 4'h0
// Flag field positions in the event vector
`define SPE_FLAG_LOOP 0
`define SPE_FLAG_PWR 1
`define SPE_FLAG_TMO 2
`define SPE_FLAG_PORT 3
`endif

// ==== hdl/spe_pkg.sv ====
package spe_pkg;
   // Sticky event flags
   typedef struct packed {
      logic portChange;
      logic stateExpiry;
      logic cablePowerFail;
      logic ringTopology;
   } spe_flags_s;

   // Per-port status sampled from the port logic
   typedef struct packed {
      logic bias;
      logic connected;
      logic disabled;
      logic eventEnable;
      logic resumeStart;
   } spe_port_s;

   // Bus reset sequencer states
   typedef enum logic [1:0] {
      SPE_IDLE = 2'b00,
      SPE_WAIT = 2'b01,
      SPE_SHORT = 2'b10,
      SPE_LONG = 2'b11
   } spe_rst_e;
endpackage

// ==== hdl/spe_event_ctrl.sv ====
`timescale 1ns/1ps
`include "spe_cfg.svh"
module spe_event_ctrl (
   input wire logic clock,
   input wire logic resetn,
   // Control writes from the link layer controller
   input wire logic ctrlWrite,
   input wire logic shortResetRequestIn,
   input wire logic accelEnableIn,
   input wire logic multiSpeedEnableIn,
   input wire logic resumeEventEnableIn,
   input wire logic [2:0] pageSelectIn,
   input wire logic [3:0] portSelectIn,
   input wire logic flagClearWrite,
   input wire spe_pkg::spe_flags_s flagClearMask,
   // Hardware events
   input wire logic treeIdTimeout,
   input wire logic stateTimeout,
   input wire logic cable_power_sense,
   input wire logic legacyNodePresent,
   input wire logic arbOpportunity,
   input wire logic busResetExternal,
   input wire logic linkActive,
   input wire spe_pkg::spe_port_s portStatus,
   input wire logic [7:0] portPageData,
   // Outputs
   output logic shortResetRequest,
   output logic accelEnable,
   output logic multiSpeedEnable,
   output logic resumeEventEnable,
   output logic [2:0] pageSelect,
   output logic [3:0] portSelect,
   output spe_pkg::spe_flags_s flags,
   output logic busResetActive,
   output logic busResetLong,
   output logic linkWake,
   output logic [7:0] portPageRead
);
   localparam int ShortCyc = `SPE_SHORT_RST_CYC;

   logic rstMeta, rstSync;
   logic cpsPrev, next_cpsPrev;
   spe_pkg::spe_port_s portPrev, next_portPrev;
   spe_pkg::spe_flags_s next_flags;
   spe_pkg::spe_rst_e state, next_state;
   logic [7:0] count, next_count;
   logic next_shortResetRequest, next_accelEnable, next_multiSpeedEnable, next_resumeEventEnable;
   logic [2:0] next_pageSelect;
   logic [3:0] next_portSelect;
   logic busResetEvent;
   logic portChanged;

   // Reset release through two flops so removal is clean
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Port selection valid only for implemented ports
   function automatic logic portImplemented(input logic [3:0] sel);
      portImplemented = (sel < 4'(`SPE_NUM_PORTS));
   endfunction

   // Any bus reset: our own sequencer or one seen on the cable
   assign busResetEvent = busResetExternal || (state == spe_pkg::SPE_SHORT) || (state == spe_pkg::SPE_LONG);

   // Status change on the port; bias ignored while disabled
   assign portChanged = portStatus.eventEnable && ((portStatus.connected != portPrev.connected) ||
      (portStatus.disabled != portPrev.disabled) ||
      (!portStatus.disabled && (portStatus.bias != portPrev.bias)));

   // Configuration bits and short reset request
   always_comb begin
      next_accelEnable = accelEnable;
      next_multiSpeedEnable = multiSpeedEnable;
      next_resumeEventEnable = resumeEventEnable;
      next_pageSelect = pageSelect;
      next_portSelect = portSelect;
      next_shortResetRequest = shortResetRequest;
      if (ctrlWrite) begin
         next_accelEnable = accelEnableIn;
         next_multiSpeedEnable = multiSpeedEnableIn;
         next_resumeEventEnable = resumeEventEnableIn;
         next_pageSelect = pageSelectIn;
         next_portSelect = portSelectIn;
         next_shortResetRequest = shortResetRequestIn;
      end
      // Bus reset wins so a request cannot survive the reset it caused
      if (busResetEvent) begin
         next_shortResetRequest = 1'b0;
      end
   end

   // Sticky flags: hardware set wins over a write-1 clear
   always_comb begin
      next_flags = flags;
      next_cpsPrev = cable_power_sense;
      next_portPrev = portStatus;
      if (flagClearWrite) begin
         next_flags = flags & ~flagClearMask;
      end
      if (treeIdTimeout) begin
         next_flags.ringTopology = 1'b1;
      end
      if (cpsPrev && !cable_power_sense) begin
         next_flags.cablePowerFail = 1'b1;
      end
      if (stateTimeout) begin
         next_flags.stateExpiry = 1'b1;
      end
      if (portChanged || (resumeEventEnable && portStatus.resumeStart)) begin
         next_flags.portChange = 1'b1;
      end
   end

   // Bus reset sequencer; state timeout forces a long reset except while a short reset is running
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         spe_pkg::SPE_IDLE: begin
            if (stateTimeout) begin
               next_state = spe_pkg::SPE_LONG;
            end else if (shortResetRequest && !busResetExternal) begin
               // A bus reset seen in the same cycle already cancelled the request
               next_state = spe_pkg::SPE_WAIT;
            end
         end
         spe_pkg::SPE_WAIT: begin
            if (stateTimeout) begin
               next_state = spe_pkg::SPE_LONG;
            end else if (busResetExternal || !shortResetRequest) begin
               // Request withdrawn or wiped by another bus reset: nothing left to start
               next_state = spe_pkg::SPE_IDLE;
            end else if (arbOpportunity) begin
               next_count = 8'h00;
               next_state = legacyNodePresent ? spe_pkg::SPE_LONG : spe_pkg::SPE_SHORT;
            end
         end
         spe_pkg::SPE_SHORT: begin
            next_count = count + 8'h01;
            if (count == 8'(ShortCyc - 1)) begin
               next_state = spe_pkg::SPE_IDLE;
            end
         end
         spe_pkg::SPE_LONG: begin
            // Long reset timing is owned by the cable arbiter; a fresh timeout asks again
            next_state = stateTimeout ? spe_pkg::SPE_LONG : spe_pkg::SPE_IDLE;
         end
         default: begin
            next_state = spe_pkg::SPE_IDLE;
         end
      endcase
   end

   // Registers; bus reset leaves configuration bits alone
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         accelEnable <= 1'b0;
         multiSpeedEnable <= 1'b0;
         resumeEventEnable <= 1'b0;
         pageSelect <= `SPE_PAGE_RST;
         portSelect <= `SPE_PORT_RST;
         shortResetRequest <= 1'b0;
         flags <= '0;
         cpsPrev <= 1'b0;
         portPrev <= '0;
         state <= spe_pkg::SPE_IDLE;
         count <= 8'h00;
      end else begin
         accelEnable <= next_accelEnable;
         multiSpeedEnable <= next_multiSpeedEnable;
         resumeEventEnable <= next_resumeEventEnable;
         pageSelect <= next_pageSelect;
         portSelect <= next_portSelect;
         shortResetRequest <= next_shortResetRequest;
         flags <= next_flags;
         cpsPrev <= next_cpsPrev;
         portPrev <= next_portPrev;
         state <= next_state;
         count <= next_count;
      end
   end

   // Sequencer outputs and link wake
   assign busResetActive = (state == spe_pkg::SPE_SHORT) || (state == spe_pkg::SPE_LONG);
   assign busResetLong = (state == spe_pkg::SPE_LONG);
   assign linkWake = flags.ringTopology && resumeEventEnable && !linkActive;

   // Port status page reads zero for unimplemented ports
   assign portPageRead = ((pageSelect == 3'h0) && !portImplemented(portSelect)) ? 8'h00 : portPageData;

   // Checks
   short_len_a: assert property (@(posedge clock) disable iff (!rstSync)
      $rose(state == spe_pkg::SPE_SHORT) |-> (state == spe_pkg::SPE_SHORT) [*8] ##19 (state == spe_pkg::SPE_IDLE))
      else $error("short reset length wrong");
   req_clear_a: assert property (@(posedge clock) disable iff (!rstSync)
      busResetEvent |=> !shortResetRequest) else $error("request survived bus reset");
   legacy_long_a: assert property (@(posedge clock) disable iff (!rstSync)
      (state == spe_pkg::SPE_WAIT) && arbOpportunity && legacyNodePresent && !stateTimeout &&
      shortResetRequest && !busResetExternal
      |=> busResetLong) else $error("legacy short not long");
   ring_set_a: assert property (@(posedge clock) disable iff (!rstSync)
      treeIdTimeout |=> flags.ringTopology) else $error("ring flag not set");
   no_sw_set_a: assert property (@(posedge clock) disable iff (!rstSync)
      $rose(flags.cablePowerFail) |-> $past(cpsPrev && !cable_power_sense)) else $error("power flag set by other");
   wake_link_a: assert property (@(posedge clock) disable iff (!rstSync)
      flags.ringTopology && resumeEventEnable && !linkActive |-> linkWake) else $error("link not woken");
   power_fail_a: assert property (@(posedge clock) disable iff (!rstSync)
      cable_power_sense ##1 !cable_power_sense |=> flags.cablePowerFail) else $error("power fail missed");
   timeout_reset_a: assert property (@(posedge clock) disable iff (!rstSync)
      stateTimeout && (state != spe_pkg::SPE_SHORT) |=> flags.stateExpiry && busResetLong)
      else $error("timeout no reset");
   accel_keep_a: assert property (@(posedge clock) disable iff (!rstSync)
      !ctrlWrite |=> $stable(accelEnable) && $stable(pageSelect) && $stable(portSelect))
      else $error("config changed without write");
   resume_flag_a: assert property (@(posedge clock) disable iff (!rstSync)
      resumeEventEnable && portStatus.resumeStart |=> flags.portChange) else $error("resume flag missed");
endmodule // spe_event_ctrl

// ==== tb/spe_link_model.sv ====
`timescale 1ns/1ps
// Arbiter stand-in: grants opportunities every cycle, or only one cycle in eight when slow
module spe_link_model (
   input wire logic clock,
   input wire logic grantOn,
   input wire logic slow,
   output logic arbOpportunity
);
   logic [2:0] phase;
   initial phase = 3'h0;
   initial arbOpportunity = 1'b0;
   // Slow grants make a pending short reset wait for a late opportunity
   always @(negedge clock) begin
      phase <= phase + 3'h1;
      arbOpportunity <= grantOn && (!slow || phase == 3'h7);
   end
endmodule // spe_link_model

// ==== tb/serial_bus_phy_event_control_bits_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module serial_bus_phy_event_control_bits_bench;
   logic clock, resetn, ctrlWrite, srIn, flagClearWrite, treeIdTimeout, stateTimeout, cable_power_sense;
   logic legacyNodePresent, arbOpportunity, busResetExternal, linkActive, grantOn, slow;
   logic [9:0] cfgIn, v;
   logic [7:0] portPageData, portPageRead;
   spe_pkg::spe_flags_s flagClearMask, flags;
   spe_pkg::spe_port_s portStatus;
   logic shortResetRequest, accelEnable, multiSpeedEnable, resumeEventEnable, busResetActive, busResetLong, linkWake;
   logic [2:0] pageSelect;
   logic [3:0] portSelect;
   int miscompares, checked, act, lng, seed;
   spe_event_ctrl dut_u (.clock(clock), .resetn(resetn), .ctrlWrite(ctrlWrite), .shortResetRequestIn(srIn),
      .accelEnableIn(cfgIn[0]), .multiSpeedEnableIn(cfgIn[1]), .resumeEventEnableIn(cfgIn[2]),
      .pageSelectIn(cfgIn[5:3]), .portSelectIn(cfgIn[9:6]), .flagClearWrite(flagClearWrite),
      .flagClearMask(flagClearMask), .treeIdTimeout(treeIdTimeout), .stateTimeout(stateTimeout),
      .cable_power_sense(cable_power_sense), .legacyNodePresent(legacyNodePresent),
      .arbOpportunity(arbOpportunity), .busResetExternal(busResetExternal), .linkActive(linkActive),
      .portStatus(portStatus), .portPageData(portPageData), .shortResetRequest(shortResetRequest),
      .accelEnable(accelEnable), .multiSpeedEnable(multiSpeedEnable), .resumeEventEnable(resumeEventEnable),
      .pageSelect(pageSelect), .portSelect(portSelect), .flags(flags), .busResetActive(busResetActive),
      .busResetLong(busResetLong), .linkWake(linkWake), .portPageRead(portPageRead));
   spe_link_model link_u (.clock(clock), .grantOn(grantOn), .slow(slow), .arbOpportunity(arbOpportunity));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Unimplemented ports read zero on the port status page; only one port exists
   function automatic logic [7:0] expRead(input logic [3:0] port, input logic [7:0] data);
      return (port >= 4'h1) ? 8'h00 : data;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic sr, input logic [9:0] c);
      ctrlWrite = 1'b1; srIn = sr; cfgIn = c;
      cyc(1);
      ctrlWrite = 1'b0;
   endtask
   task automatic clr(input logic [3:0] m);
      flagClearWrite = 1'b1; flagClearMask = m;
      cyc(1);
      flagClearWrite = 1'b0;
   endtask
   // Counts reset cycles over a fixed window, sampling before each wait so a one-cycle pulse is seen
   task automatic countReset();
      act = 0; lng = 0;
      repeat (60) begin
         if (busResetActive === 1'b1) act++;
         if (busResetLong === 1'b1) lng++;
         cyc(1);
      end
   endtask
   task automatic test_done();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      miscompares++;
      test_done();
   end
   initial begin
      seed = 32'h537917d2;
      {resetn, ctrlWrite, srIn, flagClearWrite, treeIdTimeout, stateTimeout, legacyNodePresent} = '0;
      {busResetExternal, grantOn, slow, cfgIn, portPageData, flagClearMask, portStatus} = '0;
      cable_power_sense = 1'b1; linkActive = 1'b1; checked = 0; miscompares = 0;
      cyc(10); resetn = 1'b1; cyc(3);
      `CHK("config", 11'h0, {shortResetRequest, accelEnable, multiSpeedEnable, resumeEventEnable, pageSelect, portSelect})
      `CHK("flags", 4'h0, flags)
      // Random settings survive a bus reset, the pending short request does not
      repeat (4) begin
         v = 10'($random(seed));
         wr(1'b1, v);
         `CHK("request", 1'b1, shortResetRequest)
         busResetExternal = 1'b1; cyc(1); busResetExternal = 1'b0; cyc(1);
         `CHK("request", 1'b0, shortResetRequest)
         `CHK("config", {v[0], v[1], v[2], v[5:3], v[9:6]}, {accelEnable, multiSpeedEnable, resumeEventEnable, pageSelect, portSelect})
      end
      for (int p = 0; p < 3; p++) begin
         wr(1'b0, {p[3:0], 6'h04}); portPageData = 8'($random(seed)); cyc(1);
         `CHK("pageRead", expRead(p[3:0], portPageData), portPageRead)
      end
      // Short reset with prompt and with slow opportunities, then with a legacy node present
      grantOn = 1'b1;
      for (int k = 0; k < 3; k++) begin
         slow = (k == 1); legacyNodePresent = (k == 2);
         wr(1'b1, 10'h004); countReset();
         if (k < 2) `CHK("shortCycles", 1300 / 50, act)
         else `CHK("longSeen", 1'b1, lng > 0)
         `CHK("request", 1'b0, shortResetRequest)
      end
      grantOn = 1'b0; legacyNodePresent = 1'b0;
      treeIdTimeout = 1'b1; cyc(1); treeIdTimeout = 1'b0; cyc(1);
      `CHK("flags", 4'h1, flags)
      linkActive = 1'b0; cyc(1);
      `CHK("linkWake", 1'b1, linkWake)
      linkActive = 1'b1; clr(4'h0); cyc(1);
      `CHK("flags", 4'h1, flags)
      clr(4'h1); cyc(1);
      `CHK("flags", 4'h0, flags)
      cable_power_sense = 1'b0; cyc(3); cable_power_sense = 1'b1; cyc(3);
      `CHK("flags", 4'h2, flags)
      stateTimeout = 1'b1; cyc(1); stateTimeout = 1'b0; countReset();
      `CHK("flags", 4'h6, flags)
      `CHK("timeoutReset", 1'b1, lng > 0)
      clr(4'hf); portStatus.eventEnable = 1'b1; cyc(1); portStatus.connected = 1'b1; cyc(3);
      `CHK("flags", 4'h8, flags)
      clr(4'h8); portStatus.eventEnable = 1'b0; portStatus.bias = 1'b1; cyc(3);
      `CHK("flags", 4'h0, flags)
      for (int k = 0; k < 2; k++) begin
         portStatus.resumeStart = 1'b1; cyc(1); portStatus.resumeStart = 1'b0; cyc(2);
         `CHK("flags", (k == 0) ? 4'h8 : 4'h0, flags)
         clr(4'h8); wr(1'b0, 10'h000);
      end
      // Mid-run hardware reset clears a raised flag and the settings
      wr(1'b0, 10'h3ff); treeIdTimeout = 1'b1; cyc(1); treeIdTimeout = 1'b0;
      resetn = 1'b0; cyc(2); resetn = 1'b1; cyc(3);
      `CHK("flags", 4'h0, flags)
      `CHK("config", 10'h0, {accelEnable, multiSpeedEnable, resumeEventEnable, pageSelect, portSelect})
      test_done();
   end
endmodule // serial_bus_phy_event_control_bits_bench
